// [rirqs_map.vh]
`ifndef RIRQS_MAP_VH
`define RIRQS_MAP_VH
// register offsets (byte addresses on a 32-bit Avalon-MM word bus)
`define RIRQS_ADDR_W        4
`define RIRQS_OFF_STATUS    4'h0
`define RIRQS_OFF_MASK      4'h4
`define RIRQS_OFF_WMARK     4'h8
`define RIRQS_OFF_CONFIG    4'hc
// status bit positions
`define RIRQS_B_SEQ         0
`define RIRQS_B_TX          1
`define RIRQS_B_RX          2
`define RIRQS_B_CCA         3
`define RIRQS_B_WMARK       4
`define RIRQS_B_FILT        5
`define RIRQS_B_PLL         6
`define RIRQS_B_PEND        7
`define RIRQS_W1C_BITS      8'h7f
// config bit positions
`define RIRQS_C_SAMECH      0
`define RIRQS_C_NETSEL      1
// reset values
`define RIRQS_RST_STATUS    8'h00
`define RIRQS_RST_MASK      8'h00
`define RIRQS_RST_WMARK     8'h00
`define RIRQS_RST_CONFIG    2'h0
`define RIRQS_ZERO24        24'h000000
`define RIRQS_ZERO30        30'h00000000
// sequence manager idle code
`define RIRQS_SEQ_IDLE      3'h0
// bus answer: one wait cycle on every access
`define RIRQS_ST_IDLE       1'b0
`define RIRQS_ST_DONE       1'b1
`endif

// [rirqs_events.v]
`timescale 1ns/1ps
`include "rirqs_map.vh"

// --------------------------------------------------------------
// event detection: raw modem conditions into set pulses, one cycle long except the filter event, which lasts as long as filterResultValid
// --------------------------------------------------------------
module rirqs_events (
	input  wire       mclk,
	input  wire       resetn,
	input  wire [2:0] seqState,
	input  wire       pllUnlock,
	input  wire       rxByteStrobe,
	input  wire       rxFrameStart,
	input  wire [7:0] rxWatermarkThreshold,
	input  wire       filterFailFirst,
	input  wire       filterFailSecond,
	input  wire       filterResultValid,
	input  wire       sameChannel,
	input  wire       activeNetworkSelect,
	output wire       seqEndEvent,
	output wire       pllUnlockEvent,
	output wire       watermarkEvent,
	output wire       filterEvent
);
	reg  [2:0] prevSeqState;
	reg        prevPllUnlock;
	reg  [7:0] rxCount;
	wire [7:0] next_rxCount;
	wire       selectedFail;

	always @(posedge mclk) begin
		if (!resetn) begin
			prevSeqState  <= `RIRQS_SEQ_IDLE;
			prevPllUnlock <= 1'b0;
			rxCount       <= `RIRQS_RST_WMARK;
		end else begin
			prevSeqState  <= seqState;
			prevPllUnlock <= pllUnlock;
			if (rxFrameStart)
				rxCount <= `RIRQS_RST_WMARK;
			else if (rxByteStrobe)
				rxCount <= next_rxCount;
		end
	end

	// any leave of a busy state toward idle counts, aborts included
	assign seqEndEvent = (prevSeqState != `RIRQS_SEQ_IDLE) &&
		(seqState == `RIRQS_SEQ_IDLE);
	assign pllUnlockEvent = pllUnlock && !prevPllUnlock;
	assign next_rxCount = rxCount + 8'h01;
	// fires on each byte that makes the count equal the threshold; the 8-bit count wraps after 256 bytes
	assign watermarkEvent = rxByteStrobe && !rxFrameStart &&
		(next_rxCount == rxWatermarkThreshold);
	assign selectedFail = sameChannel ?
		(filterFailFirst && filterFailSecond) :
		(activeNetworkSelect ? filterFailSecond : filterFailFirst);
	assign filterEvent = filterResultValid && selectedFail;
endmodule

// [rirqs_status.v]
`timescale 1ns/1ps
`include "rirqs_map.vh"

// --------------------------------------------------------------
// sticky write-one-to-clear flags, one per event bit
// --------------------------------------------------------------
module rirqs_status (
	input  wire       mclk,
	input  wire       resetn,
	input  wire [6:0] setPulse,
	input  wire [6:0] clearMask,
	output reg  [6:0] flags
);
	genvar i;
	generate
		for (i = 0; i < 7; i = i + 1) begin : gFlag
			always @(posedge mclk) begin
				if (!resetn)
					flags[i] <= 1'b0;
				else if (setPulse[i])
					flags[i] <= 1'b1;
				else if (clearMask[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate
endmodule

// [rirqs_top.v]
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rirqs_map.vh"

// --------------------------------------------------------------
// radio interrupt status register one, Avalon-MM slave
// --------------------------------------------------------------
module rirqs_top (
	input  wire        mclk,
	input  wire        resetn,
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output wire        waitrequest,
	output reg  [31:0] readdata,
	output wire [1:0]  response,
	input  wire [2:0]  seqState,
	input  wire        pllUnlock,
	input  wire        rxByteStrobe,
	input  wire        rxFrameStart,
	input  wire        filterFailFirst,
	input  wire        filterFailSecond,
	input  wire        filterResultValid,
	input  wire        rxFramePendingBit,
	input  wire        rxFrameDone,
	input  wire        ccaDone,
	input  wire        rxDone,
	input  wire        txDone,
	output wire        irq
);
	// ----------------------------------------------------------
	// state
	// ----------------------------------------------------------
	reg        busState;
	reg        next_busState;
	reg  [7:0] irqMask;
	reg  [7:0] rxWatermarkThreshold;
	reg  [1:0] netConfig;
	reg        rxFramePendingFlag;
	reg        badAddress;
	wire [6:0] flags;
	wire [6:0] setPulse;
	wire [6:0] clearMask;
	wire [7:0] clearBits;
	wire [7:0] statusValue;
	wire       seqEndEvent;
	wire       pllUnlockEvent;
	wire       watermarkEvent;
	wire       filterEvent;
	wire       request;
	wire       accept;
	wire       wrAccept;
	wire       laneLow;
	wire       hitStatus;
	wire       hitMask;
	wire       hitWmark;
	wire       hitConfig;

	// ----------------------------------------------------------
	// bus slave: every access waits exactly one cycle
	// ----------------------------------------------------------
	assign request = read || write;
	assign accept = request && (busState == `RIRQS_ST_DONE);
	assign waitrequest = request && (busState == `RIRQS_ST_IDLE);
	assign wrAccept = accept && write;
	assign laneLow = byteenable[0];
	assign hitStatus = (address == `RIRQS_OFF_STATUS);
	assign hitMask = (address == `RIRQS_OFF_MASK);
	assign hitWmark = (address == `RIRQS_OFF_WMARK);
	assign hitConfig = (address == `RIRQS_OFF_CONFIG);
	assign response = badAddress ? 2'h2 : 2'h0;

	always @* begin
		case (busState)
			`RIRQS_ST_IDLE: next_busState = request ?
				`RIRQS_ST_DONE : `RIRQS_ST_IDLE;
			`RIRQS_ST_DONE: next_busState = `RIRQS_ST_IDLE;
			default: next_busState = `RIRQS_ST_IDLE;
		endcase
	end

	always @(posedge mclk) begin
		if (!resetn) begin
			busState   <= `RIRQS_ST_IDLE;
			readdata   <= {`RIRQS_ZERO24, `RIRQS_RST_STATUS};
			badAddress <= 1'b0;
		end else begin
			busState <= next_busState;
			// loaded in the wait cycle so data stand when waitrequest drops
			if (waitrequest)
				badAddress <= read && !(hitStatus || hitMask || hitWmark ||
					hitConfig);
			if (waitrequest && read) begin
				if (hitStatus)
					readdata <= {`RIRQS_ZERO24, statusValue};
				else if (hitMask)
					readdata <= {`RIRQS_ZERO24, irqMask};
				else if (hitWmark)
					readdata <= {`RIRQS_ZERO24, rxWatermarkThreshold};
				else if (hitConfig)
					readdata <= {`RIRQS_ZERO30, netConfig};
				else
					readdata <= {`RIRQS_ZERO24, `RIRQS_RST_STATUS};
			end
		end
	end

	// ----------------------------------------------------------
	// software registers
	// ----------------------------------------------------------
	always @(posedge mclk) begin
		if (!resetn) begin
			irqMask              <= `RIRQS_RST_MASK;
			rxWatermarkThreshold <= `RIRQS_RST_WMARK;
			netConfig            <= `RIRQS_RST_CONFIG;
		end else if (wrAccept && laneLow) begin
			if (hitMask)
				irqMask <= writedata[7:0];
			if (hitWmark)
				rxWatermarkThreshold <= writedata[7:0];
			if (hitConfig)
				netConfig <= writedata[1:0];
		end
	end

	// frame pending is a mirror, latched per finished frame
	always @(posedge mclk) begin
		if (!resetn)
			rxFramePendingFlag <= 1'b0;
		else if (rxFrameDone)
			rxFramePendingFlag <= rxFramePendingBit;
	end

	// ----------------------------------------------------------
	// event sources and sticky flags
	// ----------------------------------------------------------
	rirqs_events uEvents (
		.mclk                 (mclk),
		.resetn               (resetn),
		.seqState             (seqState),
		.pllUnlock            (pllUnlock),
		.rxByteStrobe         (rxByteStrobe),
		.rxFrameStart         (rxFrameStart),
		.rxWatermarkThreshold (rxWatermarkThreshold),
		.filterFailFirst      (filterFailFirst),
		.filterFailSecond     (filterFailSecond),
		.filterResultValid    (filterResultValid),
		.sameChannel          (netConfig[`RIRQS_C_SAMECH]),
		.activeNetworkSelect  (netConfig[`RIRQS_C_NETSEL]),
		.seqEndEvent          (seqEndEvent),
		.pllUnlockEvent       (pllUnlockEvent),
		.watermarkEvent       (watermarkEvent),
		.filterEvent          (filterEvent)
	);

	assign setPulse[`RIRQS_B_SEQ]   = seqEndEvent;
	assign setPulse[`RIRQS_B_TX]    = txDone;
	assign setPulse[`RIRQS_B_RX]    = rxDone;
	assign setPulse[`RIRQS_B_CCA]   = ccaDone;
	assign setPulse[`RIRQS_B_WMARK] = watermarkEvent;
	assign setPulse[`RIRQS_B_FILT]  = filterEvent;
	assign setPulse[`RIRQS_B_PLL]   = pllUnlockEvent;

	// bit 7 is excluded from the clear mask so writes never touch it
	assign clearBits = writedata[7:0] & `RIRQS_W1C_BITS;
	assign clearMask = (wrAccept && hitStatus && laneLow) ?
		clearBits[6:0] : 7'h00;

	rirqs_status uStatus (
		.mclk      (mclk),
		.resetn    (resetn),
		.setPulse  (setPulse),
		.clearMask (clearMask),
		.flags     (flags)
	);

	assign statusValue = {rxFramePendingFlag, flags};

	// ----------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------
	// the mirror bit is a level, so it only interrupts if unmasked
	assign irq = |(statusValue & irqMask);
endmodule

// [rirqs_props.sv]
`timescale 1ns/1ps
module rirqs_props (
	input wire        mclk,
	input wire        resetn,
	input wire [3:0]  address,
	input wire        read,
	input wire        write,
	input wire        waitrequest,
	input wire [31:0] readdata,
	input wire [1:0]  response,
	input wire        rxFrameDone,
	input wire        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire acc = (read || write) && !waitrequest;
	// --------------------------------------------------------------
	// access steps
	// --------------------------------------------------------------
	sequence s_first;
		(read || write) && waitrequest;
	endsequence
	sequence s_rd_done;
		read && !waitrequest;
	endsequence
	a_wait_first: assert property (s_first |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_idle: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest high with no request");
	a_unmapped_err: assert property (
		s_rd_done ##0 (address[1:0] != 2'h0)
		|=> response == 2'h2 && readdata == 32'h0)
		else $error("unmapped read not refused");
	a_mapped_okay: assert property (
		acc && address[1:0] == 2'h0 |=> response == 2'h0)
		else $error("mapped access flagged as error");
	a_upper_zero: assert property (s_rd_done |=> readdata[31:8] == 24'h0)
		else $error("read data above register width not zero");
	a_data_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data changed without a read");
	a_resp_hold: assert property (!waitrequest |=> $stable(response))
		else $error("response changed without an access");
	a_irq_drop: assert property ($fell(irq) |-> $past(acc) ||
		$past(rxFrameDone) || $past(rxFrameDone, 2))
		else $error("interrupt dropped without a write");
endmodule
bind rirqs_top rirqs_props rirqs_props_i (.mclk(mclk), .resetn(resetn),
	.address(address), .read(read), .write(write),
	.waitrequest(waitrequest), .readdata(readdata), .response(response),
	.rxFrameDone(rxFrameDone), .irq(irq));

// [test_radio_irq_status_one.sv]
`timescale 1ns/1ps
module test_radio_irq_status_one;
	logic        mclk = 0, resetn = 0, read = 0, write = 0;
	logic [3:0]  address = 0;
	logic [31:0] wdata = 0, rd;
	logic [2:0]  seqState = 0;
	logic [4:0]  ev = 0;
	logic        pllUnlock = 0, rxByteStrobe = 0, rxFrameStart = 0;
	logic        filterFailFirst = 0, filterFailSecond = 0, rxPend = 0;
	wire         waitrequest, irq;
	wire  [31:0] readdata;
	wire  [1:0]  response;
	int          miscompares = 0, checks_done = 0, cyc = 0;
	logic [7:0]  e3[3] = '{8'h08, 8'h0a, 8'h0e};
	logic [4:0]  ft[6] = '{5'h05, 5'h02, 5'h14, 5'h13, 5'h0c, 5'h0f};
	rirqs_top rirqs_top_i (.mclk(mclk), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(wdata), .byteenable(4'h1),
		.waitrequest(waitrequest), .readdata(readdata), .response(response),
		.seqState(seqState), .pllUnlock(pllUnlock),
		.rxByteStrobe(rxByteStrobe), .rxFrameStart(rxFrameStart),
		.filterFailFirst(filterFailFirst), .filterFailSecond(filterFailSecond),
		.filterResultValid(ev[3]), .rxFramePendingBit(rxPend),
		.rxFrameDone(ev[4]), .ccaDone(ev[0]), .rxDone(ev[2]), .txDone(ev[1]),
		.irq(irq));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			close_out;
		end
	end
	task close_out;
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// --------------------------------------------------------------
	// bus access; evA pulses modem events in the cycle the access is accepted
	// --------------------------------------------------------------
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
			input logic [4:0] evA);
		address <= a;
		wdata <= {24'h0, d};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge mclk);
			if (waitrequest) ev <= evA;
		end while (waitrequest);
		rd = readdata;
		read <= 0;
		write <= 0;
		ev <= 0;
		@(posedge mclk);
	endtask
	task rdchk(input logic [3:0] a, input logic [7:0] e);
		bus(0, a, 8'h0, 5'h0);
		chk($sformatf("reg %h", a), rd, {24'h0, e});
	endtask
	task pulse(input logic [4:0] m);
		ev <= m;
		@(posedge mclk);
		ev <= 0;
		repeat (3) @(posedge mclk);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		resetn <= 1;
		@(posedge mclk);
		for (int i = 0; i < 16; i += 4) rdchk(i, 8'h0);
		rdchk(4'h2, 8'h0);
		chk("response", response, 2'h2);
		bus(1, 4'h4, 8'hff, 5'h0);
		chk("irq", irq, 1'b0);
		for (int i = 0; i < 3; i++) begin
			pulse(5'h1 << i);
			rdchk(0, e3[i]);
		end
		chk("irq", irq, 1'b1);
		bus(1, 4'h4, 8'h00, 5'h0);
		chk("irq", irq, 1'b0);
		bus(1, 4'h4, 8'hff, 5'h0);
		seqState <= 3'h3;
		@(posedge mclk);
		seqState <= 3'h0;
		repeat (3) @(posedge mclk);
		rdchk(0, 8'h0f);
		bus(1, 0, 8'h00, 5'h0);
		rdchk(0, 8'h0f);
		bus(1, 0, 8'h05, 5'h0);
		rdchk(0, 8'h0a);
		bus(1, 0, 8'h0a, 5'h1);
		rdchk(0, 8'h08);
		bus(1, 0, 8'h08, 5'h0);
		pllUnlock <= 1;
		repeat (3) @(posedge mclk);
		rdchk(0, 8'h40);
		repeat (4) @(posedge mclk);
		rdchk(0, 8'h40);
		bus(1, 0, 8'h40, 5'h0);
		pllUnlock <= 0;
		rdchk(0, 8'h00);
		rxPend <= 1;
		pulse(5'h10);
		rdchk(0, 8'h80);
		bus(1, 0, 8'h80, 5'h0);
		rdchk(0, 8'h80);
		rxPend <= 0;
		pulse(5'h10);
		rdchk(0, 8'h00);
		foreach (ft[i]) begin
			bus(1, 4'hc, {6'h0, ft[i][4:3]}, 5'h0);
			{filterFailFirst, filterFailSecond} <= ft[i][2:1];
			pulse(5'h8);
			rdchk(0, {2'h0, ft[i][0], 5'h0});
			bus(1, 0, 8'h20, 5'h0);
		end
		bus(1, 4'h8, 8'h03, 5'h0);
		rxFrameStart <= 1;
		@(posedge mclk);
		rxFrameStart <= 0;
		rxByteStrobe <= 1;
		repeat (2) @(posedge mclk);
		rxByteStrobe <= 0;
		repeat (3) @(posedge mclk);
		rdchk(0, 8'h00);
		rxByteStrobe <= 1;
		@(posedge mclk);
		rxByteStrobe <= 0;
		repeat (3) @(posedge mclk);
		rdchk(0, 8'h10);
		bus(1, 0, 8'hff, 5'h0);
		chk("irq", irq, 1'b0);
		close_out;
	end
endmodule
